/* hw/utxr_map.vh */
// register offsets, field positions, reset values and timing counts for the serial channel
// assumes inclusion by the channel, its assertion module and the bench
`ifndef UTXR_MAP_VH
`define UTXR_MAP_VH
`define UTXR_OFS_HOLDING   4'h0
`define UTXR_OFS_IER       4'h1
`define UTXR_OFS_ISR       4'h2
`define UTXR_OFS_FCR       4'h2
`define UTXR_OFS_LCR       4'h3
`define UTXR_OFS_MCR       4'h4
`define UTXR_OFS_LSR       4'h5
`define UTXR_OFS_EFR       4'h6
`define UTXR_OFS_OVS       4'h7
`define UTXR_OFS_FILL      4'h8
`define UTXR_LSR_ERR_LO    2
`define UTXR_LSR_THRE      5
`define UTXR_LSR_TEMT      6
`define UTXR_IER_RXRDY     0
`define UTXR_IER_THRE      1
`define UTXR_IER_RTS       6
`define UTXR_IER_CTS       7
`define UTXR_EFR_ENH       4
`define UTXR_EFR_ARTS      6
`define UTXR_EFR_ACTS      7
`define UTXR_MCR_RTS       1
`define UTXR_FCR_EN        0
`define UTXR_LCR_RST       8'h03
`define UTXR_OVS_RST       2'h0
`define UTXR_FIFO_DEPTH    5'h10
`define UTXR_TO_EXTRA      7'h0c
`define UTXR_ISR_NONE      8'h01
`define UTXR_ISR_RXERR     8'h06
`define UTXR_ISR_RXRDY     8'h04
`define UTXR_ISR_RXTO      8'h0c
`define UTXR_ISR_THRE      8'h02
`define UTXR_ISR_FLOW      8'h20
`endif

/* hw/utxr_fifo.v */
// sixteen-entry first-in first-out store used for both directions
// assumes the caller never pushes when full nor pops when empty
`timescale 1ns/1ps
module utxr_fifo #(
   parameter W = 8
) (
   input  wire         mclk,
   input  wire         arst_n,
   input  wire         flush,
   input  wire         push,
   input  wire [W-1:0] wdata,
   input  wire         pop,
   output wire [W-1:0] rdata,
   output reg  [4:0]   count_q
);
   reg [W-1:0] mem [0:15];
   reg [3:0]   wp_q;
   reg [3:0]   rp_q;

   assign rdata = mem[rp_q];

   always @(posedge mclk) begin
      if (push)
         mem[wp_q] <= wdata;
   end

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wp_q    <= 4'h0;
         rp_q    <= 4'h0;
         count_q <= 5'h00;
      end else if (flush) begin
         wp_q    <= 4'h0;
         rp_q    <= 4'h0;
         count_q <= 5'h00;
      end else begin
         if (push)
            wp_q <= wp_q + 4'h1;
         if (pop)
            rp_q <= rp_q + 4'h1;
         if (push && !pop)
            count_q <= count_q + 5'h01;
         else if (pop && !push)
            count_q <= count_q - 5'h01;
      end
   end
endmodule // utxr_fifo

/* hw/utxr_channel.v */
// one asynchronous serial channel: holding registers, fifos, shifters, line status,
// interrupt identification and automatic rts/cts flow control.
// assumes mclk is the oversampling clock (one tick per sample); serial pins are async.
`timescale 1ns/1ps
`include "utxr_map.vh"
module utxr_channel (
   input  wire       mclk,
   input  wire       arst_n,
   input  wire [3:0] addr,
   input  wire [7:0] wdata,
   input  wire       wr_stb,
   input  wire       rd_stb,
   output reg  [7:0] rdata_q,
   input  wire       rx_pin,
   input  wire       cts_n_pin,
   output reg        tx_pin_q,
   output reg        rts_n_q,
   output wire       irq
);
   localparam TX_IDLE = 4'b0001;
   localparam TX_SEND = 4'b0010;
   localparam RX_IDLE = 4'b0001;
   localparam RX_STRT = 4'b0010;
   localparam RX_DATA = 4'b0100;
   localparam RX_STOP = 4'b1000;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function [4:0] trig_lvl;
      input [1:0] sel;
      case (sel)
         2'h0:    trig_lvl = 5'd1;
         2'h1:    trig_lvl = 5'd4;
         2'h2:    trig_lvl = 5'd8;
         default: trig_lvl = 5'd14;
      endcase
   endfunction

   function [4:0] bit_ticks;
      input [1:0] ovs;
      case (ovs)
         2'h1:    bit_ticks = 5'd8;
         2'h2:    bit_ticks = 5'd4;
         default: bit_ticks = 5'd16;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   reg [7:0] ier_q, lcr_q, mcr_q, efr_q, fcr_q;
   reg [1:0] ovs_q;
   wire      fifo_en = fcr_q[`UTXR_FCR_EN];
   wire      wr_hold = wr_stb && addr == `UTXR_OFS_HOLDING;
   wire      rd_hold = rd_stb && addr == `UTXR_OFS_HOLDING;
   wire      wr_fcr  = wr_stb && addr == `UTXR_OFS_FCR;

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ier_q <= 8'h00;
         lcr_q <= `UTXR_LCR_RST;
         mcr_q <= 8'h00;
         efr_q <= 8'h00;
         fcr_q <= 8'h00;
         ovs_q <= `UTXR_OVS_RST;
      end else if (wr_stb) begin
         case (addr)
            `UTXR_OFS_IER: ier_q <= efr_q[`UTXR_EFR_ENH] ? wdata : {4'h0, wdata[3:0]};
            `UTXR_OFS_FCR: fcr_q <= {wdata[7:3], 2'h0, wdata[0]};
            `UTXR_OFS_LCR: lcr_q <= wdata;
            `UTXR_OFS_MCR: mcr_q <= wdata;
            `UTXR_OFS_EFR: efr_q <= wdata;
            `UTXR_OFS_OVS: ovs_q <= wdata[5:4];
            default: ;
         endcase
      end
   end

   wire [1:0] rx_trig_sel = fcr_q[7:6];
   wire [1:0] tx_trig_sel = fcr_q[5:4];
   wire [3:0] nbits  = {2'h0, lcr_q[1:0]} + 4'd5;
   wire       par_en = lcr_q[3];
   wire       par_ev = lcr_q[4];
   wire       stop2  = lcr_q[2];
   wire [4:0] bt     = bit_ticks(ovs_q);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   reg [1:0] rx_s_q, cts_s_q;
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rx_s_q  <= 2'h3;
         cts_s_q <= 2'h3;
      end else begin
         rx_s_q  <= {rx_s_q[0], rx_pin};
         cts_s_q <= {cts_s_q[0], cts_n_pin};
      end
   end
   wire rx_in  = rx_s_q[1];
   wire cts_n  = cts_s_q[1];

   // ----------------------------------------------------------------
   // transmit path
   // ----------------------------------------------------------------
   wire [7:0] txf_data;
   wire [4:0] txf_cnt;
   reg        hold_full_q;
   reg [7:0]  hold_q;
   reg [3:0]  tx_st_q;
   reg [10:0] tx_sh_q;
   reg [3:0]  tx_left_q;
   reg [4:0]  tx_tick_q;
   wire       tx_avail = fifo_en ? (txf_cnt != 5'h00) : hold_full_q;
   wire       cts_hold = efr_q[`UTXR_EFR_ACTS] && cts_n;
   wire       tx_load  = tx_st_q == TX_IDLE && tx_avail && !cts_hold;
   wire [7:0] tx_byte  = fifo_en ? txf_data : hold_q;
   wire       txf_push = wr_hold && fifo_en && txf_cnt != `UTXR_FIFO_DEPTH;

   utxr_fifo #(.W(8)) u_txf (
      .mclk    (mclk),
      .arst_n  (arst_n),
      .flush   (wr_fcr && (wdata[2] || !wdata[0])),
      .push    (txf_push),
      .wdata   (wdata),
      .pop     (tx_load && fifo_en),
      .rdata   (txf_data),
      .count_q (txf_cnt)
   );

   // data masked to word length; parity over the sent bits
   wire [7:0] tx_msk = tx_byte & ~(8'hff << nbits);
   wire       tx_par = ^tx_msk ^ ~par_ev;
   wire [3:0]  par_pos  = nbits + 4'd1;
   wire [10:0] tx_frame = (11'h7fe << (par_en ? par_pos : nbits)) |
                          ({10'h000, par_en & tx_par} << par_pos) | {2'h0, tx_msk, 1'b0};

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         hold_full_q <= 1'b0;
         hold_q      <= 8'h00;
         tx_st_q     <= TX_IDLE;
         tx_sh_q     <= 11'h7ff;
         tx_left_q   <= 4'h0;
         tx_tick_q   <= 5'h00;
         tx_pin_q    <= 1'b1;
      end else begin
         if (wr_hold && !fifo_en) begin
            hold_q      <= wdata;
            hold_full_q <= 1'b1;
         end else if (tx_load && !fifo_en)
            hold_full_q <= 1'b0;
         case (tx_st_q)
            TX_IDLE: begin
               tx_pin_q <= 1'b1;
               if (tx_load) begin
                  // frame shifted out lsb first: start, data, parity, stop
                  tx_sh_q   <= tx_frame;
                  tx_left_q <= nbits + {3'h0, par_en} + {3'h0, stop2} + 4'd2;
                  tx_tick_q <= 5'h00;
                  tx_st_q   <= TX_SEND;
               end
            end
            TX_SEND: begin
               tx_pin_q <= tx_sh_q[0];
               if (tx_tick_q == bt - 5'd1) begin
                  tx_tick_q <= 5'h00;
                  tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
                  tx_left_q <= tx_left_q - 4'd1;
                  if (tx_left_q == 4'd1)
                     tx_st_q <= TX_IDLE;
               end else
                  tx_tick_q <= tx_tick_q + 5'd1;
            end
            default: tx_st_q <= TX_IDLE;
         endcase
      end
   end

   wire thre = fifo_en ? (txf_cnt == 5'h00) : !hold_full_q;
   wire temt = thre && tx_st_q == TX_IDLE;

   // ----------------------------------------------------------------
   // receive path
   // ----------------------------------------------------------------
   reg [3:0]  rx_st_q;
   reg [4:0]  rx_tick_q;
   reg [3:0]  rx_idx_q;
   reg [7:0]  rx_sh_q;
   reg        rx_parb_q;
   reg        rx_prev_q;
   wire [4:0] rxf_cnt;
   wire [10:0] rxf_out;
   wire       rxf_full = rxf_cnt == `UTXR_FIFO_DEPTH;
   wire       rx_mid   = rx_tick_q == (bt >> 1) - 5'd1;
   wire       rx_end   = rx_tick_q == bt - 5'd1;
   wire       rx_done  = rx_st_q == RX_STOP && rx_end;
   wire       rx_perr  = par_en && (rx_parb_q != (^rx_sh_q ^ ~par_ev));
   wire       rx_ferr  = !rx_in;
   wire       rx_push  = rx_done && !rxf_full;
   wire       rxf_pop  = rd_hold && rxf_cnt != 5'h00;
   wire       brk      = rx_ferr && rx_sh_q == 8'h00;

   utxr_fifo #(.W(11)) u_rxf (
      .mclk    (mclk),
      .arst_n  (arst_n),
      .flush   (wr_fcr && (wdata[1] || !wdata[0])),
      .push    (rx_push),
      .wdata   ({brk, rx_ferr, rx_perr, rx_sh_q}),
      .pop     (rxf_pop),
      .rdata   (rxf_out),
      .count_q (rxf_cnt)
   );

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rx_st_q   <= RX_IDLE;
         rx_tick_q <= 5'h00;
         rx_idx_q  <= 4'h0;
         rx_sh_q   <= 8'h00;
         rx_parb_q <= 1'b0;
         rx_prev_q <= 1'b1;
      end else begin
         rx_prev_q <= rx_in;
         rx_tick_q <= rx_end ? 5'h00 : rx_tick_q + 5'd1;
         case (rx_st_q)
            RX_IDLE: begin
               // tick free-runs here so the timeout counts bit times
               if (rx_prev_q && !rx_in) begin
                  rx_tick_q <= 5'h00;
                  rx_st_q   <= RX_STRT;
               end
            end
            RX_STRT: if (rx_mid) begin
               rx_tick_q <= 5'h00;
               rx_idx_q  <= 4'h0;
               rx_sh_q   <= 8'h00;
               rx_st_q   <= rx_in ? RX_IDLE : RX_DATA;
            end
            RX_DATA: if (rx_end) begin
               // sample one full bit after the centred start sample
               if (rx_idx_q < nbits)
                  rx_sh_q[rx_idx_q[2:0]] <= rx_in;
               else
                  rx_parb_q <= rx_in;
               rx_idx_q <= rx_idx_q + 4'd1;
               if (rx_idx_q == nbits - {3'h0, ~par_en})
                  rx_st_q <= RX_STOP;
            end
            RX_STOP: if (rx_end)
               rx_st_q <= RX_IDLE;
            default: rx_st_q <= RX_IDLE;
         endcase
      end
   end

   // stop sampled one full bit after the last data or parity sample

   // ----------------------------------------------------------------
   // receive timeout: 4 words plus 12 bit times of silence
   // ----------------------------------------------------------------
   reg [6:0] to_bits_q;
   reg       rx_to_q;
   wire [6:0] to_lim = {1'b0, nbits, 2'b00} + `UTXR_TO_EXTRA;
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         to_bits_q <= 7'h00;
         rx_to_q   <= 1'b0;
      end else if (rx_push || rxf_pop || rxf_cnt == 5'h00 || rx_st_q != RX_IDLE) begin
         to_bits_q <= 7'h00;
         rx_to_q   <= 1'b0;
      end else if (rx_tick_q == 5'h00 && to_bits_q != to_lim) begin
         to_bits_q <= to_bits_q + 7'd1;
      end else if (to_bits_q == to_lim)
         rx_to_q <= 1'b1;
   end

   // ----------------------------------------------------------------
   // auto rts with hysteresis, flow events
   // ----------------------------------------------------------------
   wire [4:0] rx_trig = trig_lvl(rx_trig_sel);
   wire [4:0] rts_off = rx_trig_sel == 2'h0 ? 5'd4 : rx_trig_sel == 2'h1 ? 5'd8 : 5'd14;
   wire [4:0] rts_on  = rx_trig_sel == 2'h0 ? 5'd0 : rx_trig_sel == 2'h1 ? 5'd1 :
                        rx_trig_sel == 2'h2 ? 5'd4 : 5'd8;
   reg        rts_hold_q, cts_prev_q, flow_ev_q;
   wire       auto_rts = efr_q[`UTXR_EFR_ARTS] && mcr_q[`UTXR_MCR_RTS];
   wire       rts_n_d  = !mcr_q[`UTXR_MCR_RTS] || (auto_rts && rts_hold_q);
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rts_hold_q <= 1'b0;
         rts_n_q    <= 1'b1;
         cts_prev_q <= 1'b1;
         flow_ev_q  <= 1'b0;
      end else begin
         if (!auto_rts)
            rts_hold_q <= 1'b0;
         else if (rxf_cnt >= rts_off)
            rts_hold_q <= 1'b1;
         else if (rxf_cnt <= rts_on)
            rts_hold_q <= 1'b0;
         rts_n_q    <= rts_n_d;
         cts_prev_q <= cts_n;
         // event wins over the clearing read of the status register
         if ((ier_q[`UTXR_IER_RTS] && !rts_n_q && rts_n_d) ||
             (ier_q[`UTXR_IER_CTS] && !cts_prev_q && cts_n))
            flow_ev_q <= 1'b1;
         else if (rd_stb && addr == `UTXR_OFS_ISR)
            flow_ev_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // interrupt identification and read mux
   // ----------------------------------------------------------------
   wire rx_err_any = |rxf_out[10:8] && rxf_cnt != 5'h00;
   wire rx_rdy_int = fifo_en ? (rxf_cnt >= rx_trig) : (rxf_cnt != 5'h00);
   wire thr_int = fifo_en ? (txf_cnt < trig_lvl(tx_trig_sel)) : thre;
   reg  [7:0] interrupt_status;
   always @* begin
      interrupt_status = `UTXR_ISR_NONE;
      if (ier_q[2] && rx_err_any)
         interrupt_status = `UTXR_ISR_RXERR;
      else if (ier_q[`UTXR_IER_RXRDY] && rx_to_q)
         interrupt_status = `UTXR_ISR_RXTO;
      else if (ier_q[`UTXR_IER_RXRDY] && rx_rdy_int)
         interrupt_status = `UTXR_ISR_RXRDY;
      else if (ier_q[`UTXR_IER_THRE] && thr_int)
         interrupt_status = `UTXR_ISR_THRE;
      else if (flow_ev_q)
         interrupt_status = `UTXR_ISR_FLOW;
   end
   assign irq = !interrupt_status[0];

   wire [7:0] line_status = {1'b0, temt, thre, rxf_out[10:8] & {3{rxf_cnt != 5'h00}}, 1'b0,
                     rxf_cnt != 5'h00};

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n)
         rdata_q <= 8'h00;
      else if (rd_stb) begin
         case (addr)
            `UTXR_OFS_HOLDING: rdata_q <= rxf_out[7:0];
            `UTXR_OFS_IER:     rdata_q <= ier_q;
            `UTXR_OFS_ISR:     rdata_q <= {fifo_en, fifo_en, interrupt_status[5:0]};
            `UTXR_OFS_LCR:     rdata_q <= lcr_q;
            `UTXR_OFS_MCR:     rdata_q <= mcr_q;
            `UTXR_OFS_LSR:     rdata_q <= line_status;
            `UTXR_OFS_EFR:     rdata_q <= efr_q;
            `UTXR_OFS_OVS:     rdata_q <= {2'h0, ovs_q, 4'h0};
            `UTXR_OFS_FILL:    rdata_q <= {3'h0, rxf_cnt};
            default:           rdata_q <= 8'h00;
         endcase
      end else
         rdata_q <= 8'h00;
   end
endmodule // utxr_channel

/* verification/utxr_chan_asserts.sv */
// port-level assertions for the serial channel, bound to its top module
// assumes one clock mclk and the async active-low reset arst_n
`timescale 1ns/1ps
`include "utxr_map.vh"
module utxr_chan_asserts (
   input wire       mclk,
   input wire       arst_n,
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire       wr_stb,
   input wire       rd_stb,
   input wire [7:0] rdata_q,
   input wire       rx_pin,
   input wire       cts_n_pin,
   input wire       tx_pin_q,
   input wire       rts_n_q,
   input wire       irq
);
   logic       acts_q;
   logic [7:0] cts_cnt_q;
   // --------
   // helper: auto clear-to-send copy and cycles of held-off line
   // --------
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         acts_q    <= 1'b0;
         cts_cnt_q <= 8'h00;
      end else begin
         if (wr_stb && addr == `UTXR_OFS_EFR)
            acts_q <= wdata[`UTXR_EFR_ACTS];
         if (!acts_q || !cts_n_pin)
            cts_cnt_q <= 8'h00;
         else if (cts_cnt_q != 8'hff)
            cts_cnt_q <= cts_cnt_q + 8'h01;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   a_rdata_slot_only: assert property (!$past(rd_stb) |-> rdata_q == 8'h00)
      else $error("read data outside read slot");
   a_tx_idle_reset: assert property ($rose(arst_n) |-> tx_pin_q [*2])
      else $error("serial out not idle after reset");
   a_min_bit_low: assert property ($fell(tx_pin_q) |=> !tx_pin_q [*3])
      else $error("low bit shorter than four clocks");
   a_temt_needs_thre: assert property (rd_stb && addr == `UTXR_OFS_LSR |=>
      !rdata_q[`UTXR_LSR_TEMT] || rdata_q[`UTXR_LSR_THRE])
      else $error("tx empty without holding empty");
   a_isr_none_quiet: assert property (rd_stb && addr == `UTXR_OFS_ISR && !irq |=>
      {2'h0, rdata_q[5:0]} == `UTXR_ISR_NONE)
      else $error("status code pending without irq");
   a_fill_bounded: assert property (rd_stb && addr == `UTXR_OFS_FILL |=>
      rdata_q <= 8'h10)
      else $error("rx fill above depth");
   a_rts_fall_cause: assert property ($fell(rts_n_q) |-> $past(wr_stb) || $past(rd_stb)
      || $past(wr_stb, 2) || $past(rd_stb, 2) || $past(rd_stb, 3))
      else $error("rts asserted without host access");
   a_cts_holds_tx: assert property (acts_q && cts_cnt_q >= 8'hdc |-> tx_pin_q)
      else $error("transmit while clear-to-send off");
endmodule // utxr_chan_asserts

bind utxr_channel utxr_chan_asserts u_chk (.mclk(mclk), .arst_n(arst_n), .addr(addr),
   .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q), .rx_pin(rx_pin),
   .cts_n_pin(cts_n_pin), .tx_pin_q(tx_pin_q), .rts_n_q(rts_n_q), .irq(irq));

/* verification/utxr_remote.sv */
// remote serial partner: sends frames on request, decodes frames it hears
// assumes the bench sets bit length and word length while the line is idle
`timescale 1ns/1ps
module utxr_remote (
   input  logic       mclk,
   input  logic       line_in,
   input  logic       cts_n,
   input  logic [4:0] blen,
   input  logic [3:0] nb,
   input  logic       force_tx,
   output logic       line_out
);
   logic [7:0] got_q[$];
   logic [7:0] v;
   initial line_out = 1'b1;
   // --------
   // sender: lowlen above zero makes only a short low glitch
   // --------
   task automatic send(input logic [7:0] dat, input logic stp, input int lowlen);
      @(posedge mclk);
      while (cts_n && !force_tx) @(posedge mclk);
      line_out <= 1'b0;
      if (lowlen != 0) begin
         repeat (lowlen) @(posedge mclk);
      end else begin
         repeat (blen) @(posedge mclk);
         for (int i = 0; i < nb; i++) begin
            line_out <= dat[i];
            repeat (blen) @(posedge mclk);
         end
         line_out <= stp;
         repeat (blen) @(posedge mclk);
      end
      line_out <= 1'b1;
      repeat (blen) @(posedge mclk);
   endtask
   // receiver samples each bit at its middle
   always begin
      @(negedge line_in);
      repeat (blen / 2) @(posedge mclk);
      v = 8'h00;
      for (int i = 0; i < nb; i++) begin
         repeat (blen) @(posedge mclk);
         v[i] = line_in;
      end
      repeat (blen) @(posedge mclk);
      got_q.push_back(v);
   end
endmodule // utxr_remote

/* verification/uart_txrx_fifo_rts_cts_tb.sv */
// self-checking bench: host bus tasks, remote partner, queue models
// assumes the channel, its header and the remote partner are compiled first
`timescale 1ns/1ps
`include "utxr_map.vh"
module uart_txrx_fifo_rts_cts_tb;
   logic       mclk;
   logic       arst_n;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic       wr_stb;
   logic       rd_stb;
   logic       cts_n_pin;
   logic [4:0] blen;
   logic [3:0] nb;
   logic       force_tx;
   wire  [7:0] rdata_q;
   wire        rx_pin;
   wire        tx_pin_q;
   wire        rts_n_q;
   wire        irq;
   int         failures;
   int         checked;
   int         cyc;
   int         seed;
   logic [7:0] d;
   logic [7:0] s;
   logic [7:0] rxq[$];
   logic [7:0] txq[$];

   utxr_channel u_dut (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q), .rx_pin(rx_pin),
      .cts_n_pin(cts_n_pin), .tx_pin_q(tx_pin_q), .rts_n_q(rts_n_q), .irq(irq));
   utxr_remote u_rem (.mclk(mclk), .line_in(tx_pin_q), .cts_n(rts_n_q), .blen(blen),
      .nb(nb), .force_tx(force_tx), .line_out(rx_pin));

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         failures++;
         print_verdict;
      end
   end
   // --------
   // host bus, comparison and verdict
   // --------
   task automatic print_verdict;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge mclk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1 v = rdata_q;
   endtask
   task automatic cmp_tx(input int n);
      for (int k = 0; k < 4000 && u_rem.got_q.size() < n; k++) @(posedge mclk);
      repeat (40) @(posedge mclk);
      chk("tx count", 8'(n), 8'(u_rem.got_q.size()));
      while (txq.size() > 0 && u_rem.got_q.size() > 0)
         chk("tx byte", txq.pop_front(), u_rem.got_q.pop_front());
   endtask

   initial begin
      seed = 32'ha6f0;
      {arst_n, addr, wdata, wr_stb, rd_stb, cts_n_pin, force_tx} = '0;
      blen = 5'd16;
      nb = 4'd8;
      repeat (6) @(posedge mclk);
      arst_n <= 1'b1;
      for (int o = 0; o < 3; o++) begin
         for (int w = 0; w < 4; w++) begin
            wr(`UTXR_OFS_LCR, 8'(w));
            wr(`UTXR_OFS_OVS, 8'(o << 4));
            blen = 5'(16 >> o);
            nb = 4'(5 + w);
            d = 8'($random(seed));
            txq.push_back(d & 8'(8'hff >> (3 - w)));
            wr(`UTXR_OFS_HOLDING, d);
            rd(`UTXR_OFS_LSR, s);
            chk("busy status", 8'h20, s & 8'h60);
            cmp_tx(1);
            rd(`UTXR_OFS_LSR, s);
            chk("idle status", 8'h60, s & 8'h60);
         end
      end
      // seven data bits with even parity, parity lands in the partner's eighth bit
      wr(`UTXR_OFS_LCR, 8'h1a);
      d = 8'($random(seed));
      txq.push_back({^d[6:0], d[6:0]});
      wr(`UTXR_OFS_HOLDING, d);
      cmp_tx(1);
      wr(`UTXR_OFS_LCR, `UTXR_LCR_RST);
      force_tx = 1'b1;
      // one-clock glitch, shorter than half a bit at 4x
      u_rem.send(8'h00, 1'b1, 1);
      repeat (200) @(posedge mclk);
      rd(`UTXR_OFS_LSR, s);
      chk("false start", 8'h00, s & 8'h01);
      wr(`UTXR_OFS_FCR, 8'h01);
      wr(`UTXR_OFS_EFR, 8'h40);
      wr(`UTXR_OFS_MCR, 8'h02);
      repeat (2) @(posedge mclk);
      chk("rts on", 8'h00, {7'h0, rts_n_q});
      for (int i = 0; i < 17; i++) begin
         d = 8'($random(seed)) | 8'h01;
         u_rem.send(d, i != 2, 0);
         if (i < 16) rxq.push_back(d);
         chk("rts level", {7'h0, i >= 3}, {7'h0, rts_n_q});
      end
      rd(`UTXR_OFS_FILL, s);
      chk("rx fill", 8'h10, s);
      for (int i = 0; i < 16; i++) begin
         chk("rts held", 8'h01, {7'h0, rts_n_q});
         rd(`UTXR_OFS_LSR, s);
         chk("frame error", {4'h0, i == 2, 3'h0}, s & 8'h08);
         rd(`UTXR_OFS_HOLDING, s);
         chk("rx byte", rxq.pop_front(), s);
      end
      repeat (4) @(posedge mclk);
      chk("rts back", 8'h00, {7'h0, rts_n_q});
      wr(`UTXR_OFS_IER, 8'h01);
      u_rem.send(8'h5a, 1'b1, 0);
      repeat (4) @(posedge mclk);
      rd(`UTXR_OFS_ISR, s);
      chk("rx ready isr", 8'hc4, s);
      repeat (250) @(posedge mclk);
      rd(`UTXR_OFS_ISR, s);
      chk("rx timeout isr", 8'hcc, s);
      rd(`UTXR_OFS_HOLDING, s);
      chk("rx byte", 8'h5a, s);
      force_tx = 1'b0;
      wr(`UTXR_OFS_IER, 8'h02);
      chk("tx irq idle", 8'h01, {7'h0, irq});
      for (int i = 0; i < 16; i++) begin
         d = 8'($random(seed));
         txq.push_back(d);
         wr(`UTXR_OFS_HOLDING, d);
      end
      rd(`UTXR_OFS_LSR, s);
      chk("fifo status", 8'h00, s & 8'h60);
      chk("tx irq busy", 8'h00, {7'h0, irq});
      cmp_tx(16);
      chk("tx irq done", 8'h01, {7'h0, irq});
      wr(`UTXR_OFS_IER, 8'h00);
      chk("tx irq off", 8'h00, {7'h0, irq});
      rd(`UTXR_OFS_ISR, s);
      chk("isr none", 8'hc1, s);
      wr(`UTXR_OFS_EFR, 8'h90);
      wr(`UTXR_OFS_IER, 8'h80);
      cts_n_pin <= 1'b1;
      repeat (230) @(posedge mclk);
      rd(`UTXR_OFS_ISR, s);
      chk("cts event", 8'he0, s);
      chk("flow irq clear", 8'h00, {7'h0, irq});
      d = 8'($random(seed));
      txq.push_back(d);
      wr(`UTXR_OFS_HOLDING, d);
      repeat (400) @(posedge mclk);
      chk("tx held", 8'h00, 8'(u_rem.got_q.size()));
      cts_n_pin <= 1'b0;
      cmp_tx(1);
      print_verdict;
   end
endmodule // uart_txrx_fifo_rts_cts_tb
